//--- common/sscp_pkg.sv
// constants, field positions and types for the stepper serial configuration block
// assumes a 40 MHz system clock; the logic files refer to names here with sscp_pkg::
package sscp_pkg;

    // ************************************************************
    // serial word layout (bit index equals the D number)
    // ************************************************************
    localparam int          WORD_BITS     = 19;
    localparam int          CFG_MSB       = 18;
    localparam int          SEL_BIT       = 0;
    localparam logic [4:0]  WORD_BITS_CNT = 5'h13;
    // word 0
    localparam int          W0_DAC1_LSB   = 1;
    localparam int          W0_DAC2_LSB   = 7;
    localparam int          DAC_W         = 6;
    localparam int          W0_PHASE1     = 13;
    localparam int          W0_PHASE2     = 14;
    localparam int          W0_MODE1      = 15;
    localparam int          W0_MODE2      = 16;
    localparam int          W0_REF_SEL    = 17;
    localparam int          W0_RANGE      = 18;
    // word 1
    localparam int          W1_BLANK_LSB  = 1;
    localparam int          W1_OFF_LSB    = 3;
    localparam int          W1_FD_LSB     = 8;
    localparam int          W1_CLK_LSB    = 12;
    localparam int          W1_SR_LSB     = 14;
    localparam int          W1_IDLE       = 18;
    localparam logic [18:1] CFG_RESET     = 18'h00000;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int          SYS_CLK_HZ     = 40_000_000;
    localparam int          INT_OSC_HZ     = 4_000_000;
    localparam int          INT_OSC_DIV    = SYS_CLK_HZ / INT_OSC_HZ;
    localparam logic [3:0]  INT_OSC_DIV_M1 = 4'(INT_OSC_DIV - 1);
    localparam logic [2:0]  TIME_UNIT_M1   = 3'h7;

    typedef enum logic [1:0] {SSCP_CLK_INT = 2'b00, SSCP_CLK_EXT1 = 2'b01,
                              SSCP_CLK_EXT2 = 2'b10, SSCP_CLK_EXT4 = 2'b11} sscp_clk_src_e;
    typedef enum logic [1:0] {SSCP_SR_ACTIVE = 2'b00, SSCP_SR_OFF = 2'b01,
                              SSCP_SR_PASSIVE = 2'b10, SSCP_SR_LOW_ONLY = 2'b11} sscp_sr_mode_e;
    typedef enum logic [1:0] {SSCP_ST_BLANK = 2'b00, SSCP_ST_ON = 2'b01,
                              SSCP_ST_OFF = 2'b10} sscp_pwm_state_e;

    // blank time in master timing cycles
    function automatic logic [3:0] sscp_blank_cycles(input logic [1:0] code);
        case (code)
            2'h0:    sscp_blank_cycles = 4'h4;
            2'h1:    sscp_blank_cycles = 4'h6;
            2'h2:    sscp_blank_cycles = 4'h8;
            default: sscp_blank_cycles = 4'hc;
        endcase
    endfunction

endpackage

//--- logic/sscp_serial_rx.sv
// three-wire serial receiver: synchronises the pins and assembles 19-bit words
// assumes pins asynchronous to clk; host toggles slower than a few clk periods
`timescale 1ns/100ps
module sscp_serial_rx (
    // clock and reset
    input  wire  logic        clk,
    input  wire  logic        rst_b,
    // serial pins
    input  wire  logic        ser_clk_pin,
    input  wire  logic        ser_data_pin,
    input  wire  logic        ser_strobe_b_pin,
    // received word
    output logic              word_valid,
    output logic [18:0]       word
);
    logic [1:0] clk_s;
    logic [1:0] dat_s;
    logic [1:0] stb_s;
    logic       clk_d;
    logic       stb_d;
    logic [4:0] bits;
    wire        sclk_rise = clk_s[1] & ~clk_d;
    wire        stb_rise  = stb_s[1] & ~stb_d;
    wire        receiving = ~stb_s[1];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_s <= 2'h0;
            dat_s <= 2'h0;
            stb_s <= 2'h3;
            clk_d <= 1'b0;
            stb_d <= 1'b1;
        end else begin
            clk_s <= {clk_s[0], ser_clk_pin};
            dat_s <= {dat_s[0], ser_data_pin};
            stb_s <= {stb_s[0], ser_strobe_b_pin};
            clk_d <= clk_s[1];
            stb_d <= stb_s[1];
        end
    end

    // D18 arrives first, D0 last, so the word lands with D0 in bit 0
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            word       <= 19'h00000;
            bits       <= 5'h00;
            word_valid <= 1'b0;
        end else begin
            word_valid <= stb_rise && (bits == sscp_pkg::WORD_BITS_CNT);
            if (stb_rise) begin
                bits <= 5'h00;
            end else if (receiving && sclk_rise) begin
                word <= {word[17:0], dat_s[1]};
                bits <= (bits == 5'h1f) ? bits : bits + 5'h01;
            end
        end
    end
endmodule // sscp_serial_rx

//--- logic/sscp_pwm_timer.sv
// fixed off-time pwm timer for one bridge: blank, on, off with fast/slow decay
// assumes tick is a one-cycle pulse per master timing cycle and trip is synchronised
`timescale 1ns/100ps
module sscp_pwm_timer #(
    parameter int CNT_W = 8
) (
    // clock and reset
    input  wire  logic       clk,
    input  wire  logic       rst_b,
    // control
    input  wire  logic       tick,
    input  wire  logic       enable,
    input  wire  logic       phase,
    input  wire  logic       slow_mode,
    input  wire  logic       trip,
    input  wire  logic [1:0] blank_code,
    input  wire  logic [4:0] off_code,
    input  wire  logic [3:0] fd_code,
    // status
    output logic             source_on,
    output logic             fast_decay
);
    sscp_pkg::sscp_pwm_state_e state;
    sscp_pkg::sscp_pwm_state_e next_state;
    logic [CNT_W-1:0]          cnt;
    logic [CNT_W-1:0]          next_cnt;
    logic                      phase_q;
    wire                       phase_chg  = phase != phase_q;
    wire  [CNT_W-1:0]          blank_last = CNT_W'(sscp_pkg::sscp_blank_cycles(blank_code)) - CNT_W'(1);
    wire  [CNT_W-1:0]          off_len    = CNT_W'({off_code, sscp_pkg::TIME_UNIT_M1});
    wire  [CNT_W-1:0]          fd_len     = CNT_W'({fd_code, sscp_pkg::TIME_UNIT_M1});

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state   <= sscp_pkg::SSCP_ST_BLANK;
            cnt     <= '0;
            phase_q <= 1'b0;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            phase_q <= phase;
        end
    end

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        if (!enable || phase_chg) begin
            next_state = sscp_pkg::SSCP_ST_BLANK;
            next_cnt   = '0;
        end else begin
            case (state)
                sscp_pkg::SSCP_ST_BLANK: begin
                    // comparator not looked at while blanking
                    if (tick) begin
                        if (cnt == blank_last) begin
                            next_state = sscp_pkg::SSCP_ST_ON;
                            next_cnt   = '0;
                        end else begin
                            next_cnt = cnt + CNT_W'(1);
                        end
                    end
                end
                sscp_pkg::SSCP_ST_ON: begin
                    if (trip) begin
                        next_state = sscp_pkg::SSCP_ST_OFF;
                        next_cnt   = '0;
                    end
                end
                sscp_pkg::SSCP_ST_OFF: begin
                    if (tick) begin
                        if (cnt == off_len - CNT_W'(1)) begin
                            next_state = sscp_pkg::SSCP_ST_BLANK;
                            next_cnt   = '0;
                        end else begin
                            next_cnt = cnt + CNT_W'(1);
                        end
                    end
                end
                default: begin
                    next_state = sscp_pkg::SSCP_ST_BLANK;
                    next_cnt   = '0;
                end
            endcase
        end
    end

    assign source_on  = enable && (state != sscp_pkg::SSCP_ST_OFF);
    // fast decay runs first; a longer fast time covers the whole off-time
    assign fast_decay = enable && (state == sscp_pkg::SSCP_ST_OFF) && !slow_mode && (cnt < fd_len);
endmodule // sscp_pwm_timer

//--- logic/sscp_top.sv
// top of the stepper serial configuration and pwm timing block
// assumes pins are asynchronous to SYS_CLK (40 MHz) and the external clock is below 10 MHz

`timescale 1ns/100ps

module sscp_top (
    // clock and reset
    input  wire  logic       SYS_CLK,
    input  wire  logic       RST_B,
    // serial port
    input  wire  logic       SER_CLK,
    input  wire  logic       SER_DATA,
    input  wire  logic       SER_STROBE_B,
    // device control pins
    input  wire  logic       SLEEP_B,
    input  wire  logic       TIMING_CLOCK_PIN,
    input  wire  logic       UNDERVOLTAGE_IN,
    // current-sense comparators
    input  wire  logic       BRIDGE_ONE_TRIP,
    input  wire  logic       BRIDGE_TWO_TRIP,
    // bridge one
    output logic             BRIDGE_ONE_OUTPUT_A,
    output logic             BRIDGE_ONE_OUTPUT_B,
    output logic             BRIDGE_ONE_ENABLE,
    output logic             BRIDGE_ONE_SOURCE_ON,
    output logic             BRIDGE_ONE_FAST_DECAY,
    output logic [5:0]       BRIDGE_ONE_DAC,
    // bridge two
    output logic             BRIDGE_TWO_OUTPUT_A,
    output logic             BRIDGE_TWO_OUTPUT_B,
    output logic             BRIDGE_TWO_ENABLE,
    output logic             BRIDGE_TWO_SOURCE_ON,
    output logic             BRIDGE_TWO_FAST_DECAY,
    output logic [5:0]       BRIDGE_TWO_DAC,
    // analog setup
    output logic             REF_SELECT_EXTERNAL,
    output logic             SENSE_GAIN_RANGE,
    output logic [1:0]       SYNC_RECTIFIER_MODE,
    // timing and status
    output logic             MASTER_TIMING_CLOCK,
    output logic             CHARGE_PUMP_CLK,
    output logic             IDLE_MODE,
    output logic             UNDERVOLTAGE_FLAG
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [1:0] sleep_s;
    logic [1:0] osc_s;
    logic [1:0] uv_s;
    logic [1:0] trip1_s;
    logic [1:0] trip2_s;
    logic       osc_d;

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sleep_s <= 2'h0;
            osc_s   <= 2'h0;
            uv_s    <= 2'h0;
            trip1_s <= 2'h0;
            trip2_s <= 2'h0;
            osc_d   <= 1'b0;
        end else begin
            sleep_s <= {sleep_s[0], SLEEP_B};
            osc_s   <= {osc_s[0], TIMING_CLOCK_PIN};
            uv_s    <= {uv_s[0], UNDERVOLTAGE_IN};
            trip1_s <= {trip1_s[0], BRIDGE_ONE_TRIP};
            trip2_s <= {trip2_s[0], BRIDGE_TWO_TRIP};
            osc_d   <= osc_s[1];
        end
    end

    wire asleep    = ~sleep_s[1];
    wire uv_fault  = uv_s[1];
    wire osc_rise  = osc_s[1] & ~osc_d;

    // ************************************************************
    // serial receiver
    // ************************************************************
    logic        word_valid;
    logic [18:0] rx_word;

    sscp_serial_rx u_rx (
        .clk              (SYS_CLK),
        .rst_b            (RST_B),
        .ser_clk_pin      (SER_CLK),
        .ser_data_pin     (SER_DATA),
        .ser_strobe_b_pin (SER_STROBE_B),
        .word_valid       (word_valid),
        .word             (rx_word)
    );

    // ************************************************************
    // configuration words
    // ************************************************************
    logic [18:1] word0;
    logic [18:1] word1;

    wire clear_cfg  = asleep || uv_fault;
    wire load_word0 = word_valid && !rx_word[sscp_pkg::SEL_BIT];
    wire load_word1 = word_valid &&  rx_word[sscp_pkg::SEL_BIT];

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            word0 <= sscp_pkg::CFG_RESET;
            word1 <= sscp_pkg::CFG_RESET;
        end else if (clear_cfg) begin
            word0 <= sscp_pkg::CFG_RESET;
            word1 <= sscp_pkg::CFG_RESET;
        end else begin
            if (load_word0) begin
                word0 <= rx_word[sscp_pkg::CFG_MSB:1];
            end
            if (load_word1) begin
                word1 <= rx_word[sscp_pkg::CFG_MSB:1];
            end
        end
    end

    // ************************************************************
    // field decode
    // ************************************************************
    wire [5:0] dac1       = word0[sscp_pkg::W0_DAC1_LSB +: sscp_pkg::DAC_W];
    wire [5:0] dac2       = word0[sscp_pkg::W0_DAC2_LSB +: sscp_pkg::DAC_W];
    wire       phase1     = word0[sscp_pkg::W0_PHASE1];
    wire       phase2     = word0[sscp_pkg::W0_PHASE2];
    wire       slow1      = word0[sscp_pkg::W0_MODE1];
    wire       slow2      = word0[sscp_pkg::W0_MODE2];
    wire       ref_ext    = word0[sscp_pkg::W0_REF_SEL];
    wire       range_4    = word0[sscp_pkg::W0_RANGE];
    wire [1:0] blank_code = word1[sscp_pkg::W1_BLANK_LSB +: 2];
    wire [4:0] off_code   = word1[sscp_pkg::W1_OFF_LSB +: 5];
    wire [3:0] fd_code    = word1[sscp_pkg::W1_FD_LSB +: 4];
    wire [1:0] clk_sel    = word1[sscp_pkg::W1_CLK_LSB +: 2];
    wire [1:0] sr_mode    = word1[sscp_pkg::W1_SR_LSB +: 2];
    // test bits D16, D17 are stored but steer nothing
    wire       idle       = !word1[sscp_pkg::W1_IDLE];
    wire       run        = !idle && !asleep && !uv_fault;

    // ************************************************************
    // master timing clock selection
    // ************************************************************
    logic [3:0] int_div;
    logic [1:0] ext_div;
    logic       master_tick;
    logic       next_tick;
    wire        clock_source_select_low  = clk_sel[0];
    wire        clock_source_select_high = clk_sel[1];
    wire        int_tick = (int_div == sscp_pkg::INT_OSC_DIV_M1);

    always_comb begin
        case (sscp_pkg::sscp_clk_src_e'({clock_source_select_high, clock_source_select_low}))
            sscp_pkg::SSCP_CLK_INT:  next_tick = int_tick;
            sscp_pkg::SSCP_CLK_EXT1: next_tick = osc_rise;
            sscp_pkg::SSCP_CLK_EXT2: next_tick = osc_rise && ext_div[0];
            sscp_pkg::SSCP_CLK_EXT4: next_tick = osc_rise && (ext_div == 2'h3);
            default:                 next_tick = int_tick;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            int_div     <= 4'h0;
            ext_div     <= 2'h0;
            master_tick <= 1'b0;
        end else begin
            int_div     <= int_tick ? 4'h0 : int_div + 4'h1;
            ext_div     <= osc_rise ? ext_div + 2'h1 : ext_div;
            master_tick <= next_tick && !asleep;
        end
    end

    // ************************************************************
    // pwm timers
    // ************************************************************
    wire [1:0] bridge_en  = {run && (dac2 != 6'h00), run && (dac1 != 6'h00)};
    wire [1:0] phase_v    = {phase2, phase1};
    wire [1:0] slow_v     = {slow2, slow1};
    wire [1:0] trip_v     = {trip2_s[1], trip1_s[1]};
    wire [1:0] source_on_v;
    wire [1:0] fast_v;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_bridge
            sscp_pwm_timer #(
                .CNT_W (8)
            ) u_timer (
                .clk        (SYS_CLK),
                .rst_b      (RST_B),
                .tick       (master_tick),
                .enable     (bridge_en[gi]),
                .phase      (phase_v[gi]),
                .slow_mode  (slow_v[gi]),
                .trip       (trip_v[gi]),
                .blank_code (blank_code),
                .off_code   (off_code),
                .fd_code    (fd_code),
                .source_on  (source_on_v[gi]),
                .fast_decay (fast_v[gi])
            );
        end
    endgenerate

    // ************************************************************
    // output registers
    // ************************************************************
    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            BRIDGE_ONE_OUTPUT_A   <= 1'b0;
            BRIDGE_ONE_OUTPUT_B   <= 1'b0;
            BRIDGE_ONE_ENABLE     <= 1'b0;
            BRIDGE_ONE_SOURCE_ON  <= 1'b0;
            BRIDGE_ONE_FAST_DECAY <= 1'b0;
            BRIDGE_ONE_DAC        <= 6'h00;
        end else begin
            // drivers off when disabled; otherwise direction follows phase
            BRIDGE_ONE_OUTPUT_A   <= bridge_en[0] &&  phase1;
            BRIDGE_ONE_OUTPUT_B   <= bridge_en[0] && !phase1;
            BRIDGE_ONE_ENABLE     <= bridge_en[0];
            BRIDGE_ONE_SOURCE_ON  <= source_on_v[0];
            BRIDGE_ONE_FAST_DECAY <= fast_v[0];
            BRIDGE_ONE_DAC        <= dac1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            BRIDGE_TWO_OUTPUT_A   <= 1'b0;
            BRIDGE_TWO_OUTPUT_B   <= 1'b0;
            BRIDGE_TWO_ENABLE     <= 1'b0;
            BRIDGE_TWO_SOURCE_ON  <= 1'b0;
            BRIDGE_TWO_FAST_DECAY <= 1'b0;
            BRIDGE_TWO_DAC        <= 6'h00;
        end else begin
            BRIDGE_TWO_OUTPUT_A   <= bridge_en[1] &&  phase2;
            BRIDGE_TWO_OUTPUT_B   <= bridge_en[1] && !phase2;
            BRIDGE_TWO_ENABLE     <= bridge_en[1];
            BRIDGE_TWO_SOURCE_ON  <= source_on_v[1];
            BRIDGE_TWO_FAST_DECAY <= fast_v[1];
            BRIDGE_TWO_DAC        <= dac2;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B) begin
        if (!RST_B) begin
            REF_SELECT_EXTERNAL <= 1'b0;
            SENSE_GAIN_RANGE    <= 1'b0;
            SYNC_RECTIFIER_MODE <= 2'h0;
            MASTER_TIMING_CLOCK <= 1'b0;
            CHARGE_PUMP_CLK     <= 1'b0;
            IDLE_MODE           <= 1'b1;
            UNDERVOLTAGE_FLAG   <= 1'b0;
        end else begin
            REF_SELECT_EXTERNAL <= ref_ext;
            SENSE_GAIN_RANGE    <= range_4;
            SYNC_RECTIFIER_MODE <= sr_mode;
            MASTER_TIMING_CLOCK <= master_tick;
            // charge pump toggles on each master tick and stops in idle or sleep
            if (!run) begin
                CHARGE_PUMP_CLK <= 1'b0;
            end else if (master_tick) begin
                CHARGE_PUMP_CLK <= !CHARGE_PUMP_CLK;
            end
            IDLE_MODE           <= idle;
            UNDERVOLTAGE_FLAG   <= uv_fault;
        end
    end

endmodule // sscp_top

//--- verif/sscp_host_model.sv
// host side of the three-wire configuration port
// assumes clk is the bench clock; the bench calls send at a falling edge
`timescale 1ns/100ps
module sscp_host_model (
    // clock
    input  wire logic clk,
    // serial pins
    output logic      ser_clk,
    output logic      ser_data,
    output logic      ser_strobe_b
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_strobe_b = 1'b1;
    end
    // shifts the top n bits msb first, four clocks per half period
    task automatic send(input logic [18:0] w, input int n);
        ser_strobe_b = 1'b0;
        for (int i = 18; i > 18 - n; i--) begin
            ser_data = w[i];
            repeat (4) @(negedge clk);
            ser_clk = 1'b1;
            repeat (4) @(negedge clk);
            ser_clk = 1'b0;
        end
        ser_strobe_b = 1'b1;
        // released line shows no stale bit
        ser_data = ~ser_data;
        repeat (4) @(negedge clk);
    endtask
endmodule // sscp_host_model

//--- verif/sscp_checker.sv
// port assertions for sscp_top
// assumes it is bound into sscp_top
`timescale 1ns/100ps
module sscp_checker (
    // clock and reset
    input wire logic       SYS_CLK,
    input wire logic       RST_B,
    // watched ports
    input wire logic       SLEEP_B,
    input wire logic       UNDERVOLTAGE_IN,
    input wire logic       BRIDGE_ONE_OUTPUT_A,
    input wire logic       BRIDGE_ONE_OUTPUT_B,
    input wire logic       BRIDGE_ONE_ENABLE,
    input wire logic       BRIDGE_ONE_SOURCE_ON,
    input wire logic       BRIDGE_ONE_FAST_DECAY,
    input wire logic [5:0] BRIDGE_ONE_DAC,
    input wire logic       BRIDGE_TWO_SOURCE_ON,
    input wire logic       BRIDGE_TWO_FAST_DECAY,
    input wire logic       MASTER_TIMING_CLOCK,
    input wire logic       CHARGE_PUMP_CLK,
    input wire logic       IDLE_MODE,
    input wire logic       UNDERVOLTAGE_FLAG
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    sequence s_blank_start;
        $rose(BRIDGE_ONE_SOURCE_ON);
    endsequence
    sequence s_sleep_held;
        !SLEEP_B [*6];
    endsequence
    a_off_drivers_low: assert property (!BRIDGE_ONE_ENABLE |-> !BRIDGE_ONE_OUTPUT_A && !BRIDGE_ONE_OUTPUT_B)
        else $error("disabled bridge drives");
    a_phase_opposite: assert property (BRIDGE_ONE_ENABLE |-> BRIDGE_ONE_OUTPUT_A != BRIDGE_ONE_OUTPUT_B)
        else $error("outputs not opposite");
    a_enable_needs_code: assert property (BRIDGE_ONE_ENABLE |-> BRIDGE_ONE_DAC != 6'h00 && !IDLE_MODE)
        else $error("enabled with zero code or idle");
    a_idle_pump_stop: assert property (IDLE_MODE && $past(IDLE_MODE) |-> !CHARGE_PUMP_CLK)
        else $error("pump runs in idle");
    a_sleep_clears: assert property (s_sleep_held |-> IDLE_MODE && BRIDGE_ONE_DAC == 6'h00)
        else $error("sleep kept config");
    a_tick_single: assert property (MASTER_TIMING_CLOCK |=> !MASTER_TIMING_CLOCK)
        else $error("tick wider than one cycle");
    a_blank_holds: assert property (s_blank_start |=> (BRIDGE_ONE_SOURCE_ON || !BRIDGE_ONE_ENABLE) [*8])
        else $error("source dropped in blank");
    a_fast_in_off: assert property (BRIDGE_ONE_FAST_DECAY |-> !BRIDGE_ONE_SOURCE_ON)
        else $error("fast decay while source on");
    a_fast2_in_off: assert property (BRIDGE_TWO_FAST_DECAY |-> !BRIDGE_TWO_SOURCE_ON)
        else $error("bridge two fast decay while source on");
    a_uv_flag_seen: assert property (UNDERVOLTAGE_IN [*5] |-> UNDERVOLTAGE_FLAG)
        else $error("undervoltage flag missing");
endmodule // sscp_checker
bind sscp_top sscp_checker i_sscp_checker (.SYS_CLK, .RST_B, .SLEEP_B, .UNDERVOLTAGE_IN, .BRIDGE_ONE_OUTPUT_A,
    .BRIDGE_ONE_OUTPUT_B, .BRIDGE_ONE_ENABLE, .BRIDGE_ONE_SOURCE_ON, .BRIDGE_ONE_FAST_DECAY, .BRIDGE_ONE_DAC,
    .BRIDGE_TWO_SOURCE_ON, .BRIDGE_TWO_FAST_DECAY,
    .MASTER_TIMING_CLOCK, .CHARGE_PUMP_CLK, .IDLE_MODE, .UNDERVOLTAGE_FLAG);

//--- verif/sscp_tb_top.sv
// self-checking bench for sscp_top
// assumes the host model drives the serial pins; notes queue up for a monitor
`timescale 1ns/100ps
module sscp_tb_top;
    logic        clk = 1'b0, rst_b = 1'b0, slp_b = 1'b1, osc = 1'b0, uv = 1'b0, t1 = 1'b0, t2 = 1'b0;
    wire         sc, sd, ss;
    logic        a1, b1, e1, s1, f1, a2, b2, e2, rx, gr, mtc, idle, uvf;
    logic [5:0]  d1, d2;
    logic [1:0]  sr;
    logic [18:0] w0 = 19'h0, w1 = 19'h0;
    logic [31:0] g, f, exp_q[$], seen_q[$];
    int          bad_count = 0, tests_run = 0, seed = 32'hc290;
    event        got;
    wire  [31:0] cfg = {9'h0, d1, d2, a1, b1, a2, b2, e1, e2, rx, gr, sr, idle};
    always #12.5 clk = ~clk;
    always #100 osc = ~osc;
    sscp_host_model i_sscp_host_model (.clk(clk), .ser_clk(sc), .ser_data(sd), .ser_strobe_b(ss));
    sscp_top i_sscp_top (.SYS_CLK(clk), .RST_B(rst_b), .SER_CLK(sc), .SER_DATA(sd), .SER_STROBE_B(ss),
        .SLEEP_B(slp_b), .TIMING_CLOCK_PIN(osc), .UNDERVOLTAGE_IN(uv), .BRIDGE_ONE_TRIP(t1), .BRIDGE_TWO_TRIP(t2),
        .BRIDGE_ONE_OUTPUT_A(a1), .BRIDGE_ONE_OUTPUT_B(b1), .BRIDGE_ONE_ENABLE(e1), .BRIDGE_ONE_SOURCE_ON(s1),
        .BRIDGE_ONE_FAST_DECAY(f1), .BRIDGE_ONE_DAC(d1), .BRIDGE_TWO_OUTPUT_A(a2), .BRIDGE_TWO_OUTPUT_B(b2),
        .BRIDGE_TWO_ENABLE(e2), .BRIDGE_TWO_SOURCE_ON(), .BRIDGE_TWO_FAST_DECAY(), .BRIDGE_TWO_DAC(d2),
        .REF_SELECT_EXTERNAL(rx), .SENSE_GAIN_RANGE(gr), .SYNC_RECTIFIER_MODE(sr), .MASTER_TIMING_CLOCK(mtc),
        .CHARGE_PUMP_CLK(), .IDLE_MODE(idle), .UNDERVOLTAGE_FLAG(uvf));
    function automatic logic [31:0] exp_cfg(input logic [18:0] x, input logic [18:0] y);
        logic n1, n2;
        n1 = (x[6:1] != 6'h0) && y[18];
        n2 = (x[12:7] != 6'h0) && y[18];
        return {9'h0, x[6:1], x[12:7], n1 & x[13], n1 & ~x[13], n2 & x[14], n2 & ~x[14], n1, n2,
                x[17], x[18], y[15:14], ~y[18]};
    endfunction
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic note(input logic [31:0] s, input logic [31:0] e);
        exp_q.push_back(e);
        seen_q.push_back(s);
        ->got;
    endtask
    // drain everything noted so far; two notes in one time step raise one wake-up
    always @(got) while (seen_q.size() > 0) check(seen_q.pop_front(), exp_q.pop_front());
    task automatic put(input logic [18:0] w, input int n);
        i_sscp_host_model.send(w, n);
        repeat (8) @(negedge clk);
        if (n == 19 && w[0]) w1 = w;
        else if (n == 19) w0 = w;
        note(cfg, exp_cfg(w0, w1));
    endtask
    // counts ticks over one off-time and its fast part
    task automatic pwm(output logic [31:0] ot, output logic [31:0] ft);
        ot = 0;
        ft = 0;
        for (int t = 0; t < 3000 && s1 !== 1'b0; t++) @(negedge clk);
        for (int t = 0; t < 3000 && s1 !== 1'b1; t++) begin
            ot += (mtc === 1'b1);
            ft += (mtc === 1'b1 && f1 === 1'b1);
            t2 = 1'($random(seed));
            @(negedge clk);
        end
    endtask
    task automatic gap(output logic [31:0] n);
        for (int t = 0; t < 99 && mtc !== 1'b1; t++) @(negedge clk);
        @(negedge clk);
        for (n = 1; n < 99 && mtc !== 1'b1; n++) @(negedge clk);
    endtask
    task automatic report_and_stop;
        $display("tests_run %0d bad_count %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #1_000_000;
        bad_count++;
        report_and_stop;
    end
    initial begin
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        for (int m = 0; m < 4; m++) put({3'h4, 2'(m), 2'h0, 4'h1, 5'h02, 2'(m), 1'b1}, 19);
        $display("rectifier modes done");
        repeat (40) @(negedge clk); // IDLE_MODE stays low before any driver is enabled (wait scaled down)
        for (int k = 0; k < 6; k++) put(19'($random(seed)) & (k ? 19'h7fffe : 19'h7ff80), 19);
        put(w0 ^ 19'h7fffe, 18);
        $display("word 0 and short write done");
        for (int c = 0; c < 4; c++) begin
            put({w1[18:14], 2'(c), w1[11:0]}, 19);
            gap(g);
            gap(g);
            note(g, c == 0 ? 32'h0a : 32'h08 << (c - 1));
        end
        put({w0[18:16], 1'b0, w0[14:7], 6'h05, 1'b0}, 19);
        for (int r = 0; r < 2; r++) begin
            put({w1[18:12], r ? 4'hf : 4'h1, w1[7:0]}, 19);
            t1 = 1'b1;
            pwm(g, f);
            note(g, 32'h17);
            note(f, r ? 32'h17 : 32'h0f);
        end
        t1 = 1'b0;
        $display("clock select and pwm timing done");
        slp_b = 1'b0;
        repeat (8) @(negedge clk);
        note(cfg, exp_cfg(19'h0, 19'h0));
        slp_b = 1'b1;
        uv = 1'b1;
        repeat (8) @(negedge clk);
        note(uvf, 32'h1);
        uv = 1'b0;
        $display("sleep and undervoltage done");
        @(negedge clk);
        report_and_stop;
    end
endmodule // sscp_tb_top
